// ==== hw/umbs_top.v ====
// Serial port with multidrop filtering, shared data register and Avalon-MM slave.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "umbs_defines.vh"

module umbs_top (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        baud_tick_x16,
    input  wire        rxd_pin,
    output reg         txd_pin,
    input  wire        lut_zero_out,
    input  wire        lut_one_out,
    output wire        usart_serial_out,
    output wire        infrared_enable,
    output wire        dma_request
);
    // Bus state and decode.
    reg         bus_done;
    wire        bus_req   = avs_read | avs_write;
    wire        bus_fire  = bus_req & bus_done;
    wire [1:0]  reg_idx   = avs_address[3:2];
    wire        in_map    = (avs_address[1:0] == 2'h0) && (reg_idx != 2'h3);
    wire        lane0     = avs_byteenable[0];
    wire        wr_data   = bus_fire & avs_write & in_map & lane0 &
                            (reg_idx == `UMBS_IDX_DATA);
    wire        wr_status = bus_fire & avs_write & in_map & lane0 &
                            (reg_idx == `UMBS_IDX_STATUS);
    wire        wr_ctrl   = bus_fire & avs_write & in_map &
                            (reg_idx == `UMBS_IDX_CTRL);
    wire        rd_data   = bus_fire & avs_read & in_map &
                            (reg_idx == `UMBS_IDX_DATA);

    // Control register fields.
    reg  [`UMBS_CT_WIDTH-1:0] ctrl;
    wire        rx_en      = ctrl[`UMBS_CT_RX_EN];
    wire        tx_en      = ctrl[`UMBS_CT_TX_EN];
    wire        filter_on  = ctrl[`UMBS_CT_FILTER];
    wire        single_pin = ctrl[`UMBS_CT_SINGLE_PIN];
    wire        var_len    = ctrl[`UMBS_CT_VAR_LEN];
    wire        two_stop   = ctrl[`UMBS_CT_TWO_STOP];
    wire [2:0]  size_code  = ctrl[`UMBS_CT_SIZE_HI:`UMBS_CT_SIZE_LO];
    // Codes above four read back as stored but run as nine bits.
    wire [3:0]  nbits      = (size_code > 3'h4) ? 4'h9 : ({1'b0, size_code} + 4'h5);
    wire        nine_bit   = (nbits == 4'h9);
    // Double speed is ignored while the infrared modulator is on.
    wire        fast       = ctrl[`UMBS_CT_DOUBLE] & ~ctrl[`UMBS_CT_INFRARED];
    wire [4:0]  ticks_bit  = fast ? `UMBS_TICKS_DOUBLE : `UMBS_TICKS_NORMAL;
    wire [4:0]  ticks_half = {1'b0, ticks_bit[4:1]};

    assign infrared_enable = ctrl[`UMBS_CT_INFRARED];

    // Synchronised line inputs.
    wire        rxd_s;
    wire        lookup_table_zero_s;

    umbs_sync #(.RESET_VALUE(1'b1)) u_sync_rxd (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (rxd_pin),
        .sync_out (rxd_s)
    );

    umbs_sync #(.RESET_VALUE(1'b1)) u_sync_lookup_table_zero (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (lut_zero_out),
        .sync_out (lookup_table_zero_s)
    );

    // Transmitter state.
    localparam TX_IDLE  = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA  = 3'h2;
    localparam TX_STOP1 = 3'h3;
    localparam TX_STOP2 = 3'h4;

    reg  [2:0]  tx_state;
    reg  [4:0]  tx_tick;
    reg  [3:0]  tx_bit;
    reg  [8:0]  tx_shift;
    reg         tx_line;
    reg  [7:0]  tx_buf;
    reg         dre;
    reg         txc;
    wire        tx_bit_end = baud_tick_x16 && (tx_tick == ticks_bit - 5'h1);
    wire        tx_load    = tx_en && !dre && (tx_state == TX_IDLE);

    assign usart_serial_out = tx_line;

    // Receive path source: own transmitter, lookup table or pin.
    wire        rx_src = single_pin ? tx_line :
                         (ctrl[`UMBS_CT_DECODE] ? lookup_table_zero_s : rxd_s);

    // Receiver state.
    localparam RX_IDLE  = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA  = 2'h2;
    localparam RX_STOP  = 2'h3;

    reg  [1:0]  rx_state;
    reg  [4:0]  rx_tick;
    reg  [3:0]  rx_bit;
    reg  [8:0]  rx_shift;
    wire        rx_sample = baud_tick_x16 && (rx_tick == ticks_bit - 5'h1);
    wire        rx_mid    = baud_tick_x16 && (rx_tick == ticks_half - 5'h1);
    wire        rx_done   = rx_en && (rx_state == RX_STOP) && rx_sample;

    // Right-align the received bits; unused upper bits come out zero.
    wire [8:0]  rx_word   = rx_shift >> (4'h9 - nbits);
    // The frame type marker is the ninth bit, or the first stop bit.
    wire        marker    = nine_bit ? rx_word[8] : rx_src;
    // A short-character receiver in filtering mode reads its first stop as the marker.
    wire        stop_is_marker = filter_on && !nine_bit;
    wire        frame_err = !stop_is_marker && !rx_src;
    // Marker one means address; data frames are dropped while filtering.
    wire        drop      = filter_on && !marker;
    wire        push      = rx_done && !drop;

    // FIFO entry: {frame error, ninth bit, data byte}.
    wire [9:0]  head;
    wire        fifo_empty;
    wire        fifo_full;
    wire        pop = rd_data;

    umbs_rx_fifo #(.WIDTH(10)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .flush     (!rx_en),
        .push      (push),
        .push_data ({frame_err, rx_word}),
        .pop       (pop),
        .head_data (head),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // Receive status flags.
    reg         rxc_ack;
    reg         data_reception_flag_ack;
    reg         rxc_sticky;
    reg         ovf;
    wire        rxc_std = !fifo_empty && !rxc_ack;
    wire        data_reception_flag    = var_len && !fifo_empty && !data_reception_flag_ack;
    wire        rxc     = var_len ? rxc_sticky : rxc_std;
    wire [7:0]  status  = {rxc, txc, dre, head[9], ovf, 1'b0, 1'b0,
                           var_len ? data_reception_flag : head[8]};

    // The data-reception flag doubles as the DMA trigger.
    assign dma_request = data_reception_flag;

    // A request is held one cycle, then answered with waitrequest low.
    assign avs_waitrequest = bus_req & ~bus_done;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_done <= 1'b0;
        end else begin
            bus_done <= bus_req & ~bus_done;
        end
    end

    // Read data is captured in the wait cycle so it stands at the answering edge.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !bus_done) begin
            avs_readdata <= 32'h00000000;
            if (in_map) begin
                case (reg_idx)
                    `UMBS_IDX_DATA: begin
                        avs_readdata <= {24'h000000, head[7:0]};
                    end
                    `UMBS_IDX_STATUS: begin
                        avs_readdata <= {24'h000000, status};
                    end
                    `UMBS_IDX_CTRL: begin
                        avs_readdata <= {18'h00000, ctrl};
                    end
                    default: begin
                        avs_readdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Control register; the upper lane carries the high fields.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `UMBS_CTRL_RESET;
        end else if (wr_ctrl) begin
            if (avs_byteenable[0]) begin
                ctrl[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                ctrl[13:8] <= avs_writedata[13:8];
            end
        end
    end

    // Transmit buffer and its empty flag; a write while full is discarded.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buf <= `UMBS_DATA_RESET;
            dre    <= 1'b1;
        end else if (wr_data && dre) begin
            tx_buf <= avs_writedata[7:0];
            dre    <= 1'b0;
        end else if (tx_load) begin
            dre <= 1'b1;
        end
    end

    // Transmit shifter: start, data bits LSB first, one or two stop bits.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state <= TX_IDLE;
            tx_tick  <= 5'h00;
            tx_bit   <= 4'h0;
            tx_shift <= 9'h000;
            tx_line  <= 1'b1;
        end else begin
            if (tx_state != TX_IDLE && baud_tick_x16) begin
                tx_tick <= tx_bit_end ? 5'h00 : tx_tick + 5'h01;
            end
            case (tx_state)
                TX_IDLE: begin
                    tx_line <= 1'b1;
                    tx_tick <= 5'h00;
                    if (tx_load) begin
                        // Bits beyond the character size are never shifted out.
                        tx_shift <= {ctrl[`UMBS_CT_TX_BIT8], tx_buf};
                        tx_line  <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_line  <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_bit   <= 4'h1;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit == nbits) begin
                            tx_line  <= 1'b1;
                            tx_state <= TX_STOP1;
                        end else begin
                            tx_line  <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[8:1]};
                            tx_bit   <= tx_bit + 4'h1;
                        end
                    end
                end
                TX_STOP1: begin
                    if (tx_bit_end) begin
                        tx_state <= two_stop ? TX_STOP2 : TX_IDLE;
                    end
                end
                TX_STOP2: begin
                    if (tx_bit_end) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Transmit-complete: set at frame end with nothing buffered; set beats clear.
    wire tx_frame_end = tx_bit_end &&
                        ((tx_state == TX_STOP2) || (tx_state == TX_STOP1 && !two_stop));

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txc <= 1'b0;
        end else if (tx_frame_end && dre) begin
            txc <= 1'b1;
        end else if (wr_status && avs_writedata[`UMBS_ST_TXC]) begin
            txc <= 1'b0;
        end
    end

    // Pin drive: own serial output or the encoding lookup table, from a flop.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txd_pin <= 1'b1;
        end else begin
            txd_pin <= ctrl[`UMBS_CT_ENCODE] ? lut_one_out : tx_line;
        end
    end

    // Receiver: mid-bit start check, then one sample per bit time.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= RX_IDLE;
            rx_tick  <= 5'h00;
            rx_bit   <= 4'h0;
            rx_shift <= 9'h000;
        end else if (!rx_en) begin
            rx_state <= RX_IDLE;
            rx_tick  <= 5'h00;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_tick <= 5'h00;
                    if (!rx_src) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        rx_tick  <= 5'h00;
                        rx_bit   <= 4'h0;
                        rx_state <= rx_src ? RX_IDLE : RX_DATA;
                    end else if (baud_tick_x16) begin
                        rx_tick <= rx_tick + 5'h01;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_tick  <= 5'h00;
                        rx_shift <= {rx_src, rx_shift[8:1]};
                        rx_bit   <= rx_bit + 4'h1;
                        if (rx_bit == nbits - 4'h1) begin
                            rx_state <= RX_STOP;
                        end
                    end else if (baud_tick_x16) begin
                        rx_tick <= rx_tick + 5'h01;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_tick  <= 5'h00;
                        rx_state <= RX_IDLE;
                    end else if (baud_tick_x16) begin
                        rx_tick <= rx_tick + 5'h01;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Overflow: a kept character met a full FIFO; valid until the next data read.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf <= 1'b0;
        end else if (!rx_en) begin
            ovf <= 1'b0;
        end else if (push && fifo_full) begin
            ovf <= 1'b1;
        end else if (pop) begin
            ovf <= 1'b0;
        end
    end

    // Write-one acknowledges hide pending data until the next character lands.
    // A push in the same cycle as the write wins, so no arrival is missed.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxc_ack  <= 1'b0;
            data_reception_flag_ack <= 1'b0;
        end else if (push || fifo_empty) begin
            rxc_ack  <= 1'b0;
            data_reception_flag_ack <= 1'b0;
        end else if (wr_status) begin
            if (avs_writedata[`UMBS_ST_RXC] && !var_len) begin
                rxc_ack <= 1'b1;
            end
            if (avs_writedata[`UMBS_ST_BIT0] && var_len) begin
                data_reception_flag_ack <= 1'b1;
            end
        end
    end

    // Variable-length receive-complete: sticky on a valid stop, write-one clears.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxc_sticky <= 1'b0;
        end else if (!rx_en) begin
            rxc_sticky <= 1'b0;
        end else if (var_len && push && rx_src) begin
            rxc_sticky <= 1'b1;
        end else if (wr_status && avs_writedata[`UMBS_ST_RXC]) begin
            rxc_sticky <= 1'b0;
        end
    end
endmodule // umbs_top

`default_nettype wire

// ==== hw/umbs_defines.vh ====
// Constants of the multidrop serial port block: register map, fields, resets, timing.
`ifndef UMBS_DEFINES_VH
`define UMBS_DEFINES_VH

// Register indices; byte address is four times the index.
`define UMBS_IDX_DATA        2'h0
`define UMBS_IDX_STATUS      2'h1
`define UMBS_IDX_CTRL        2'h2

// Status bit positions.
`define UMBS_ST_RXC          7
`define UMBS_ST_TXC          6
`define UMBS_ST_DRE          5
`define UMBS_ST_FRAMING_ERROR_FLAG         4
`define UMBS_ST_OVF          3
`define UMBS_ST_BIT0         0

// Control bit positions.
`define UMBS_CT_RX_EN        0
`define UMBS_CT_TX_EN        1
`define UMBS_CT_FILTER       2
`define UMBS_CT_SINGLE_PIN   3
`define UMBS_CT_DOUBLE       4
`define UMBS_CT_INFRARED     5
`define UMBS_CT_TWO_STOP     6
`define UMBS_CT_VAR_LEN      7
`define UMBS_CT_ENCODE       8
`define UMBS_CT_DECODE       9
`define UMBS_CT_TX_BIT8      10
`define UMBS_CT_SIZE_LO      11
`define UMBS_CT_SIZE_HI      13
`define UMBS_CT_WIDTH        14

// Reset values.
`define UMBS_CTRL_RESET      14'h0000
`define UMBS_DATA_RESET      8'h00

// Oversampling ticks per bit at normal and double speed.
`define UMBS_TICKS_NORMAL    5'h10
`define UMBS_TICKS_DOUBLE    5'h08

// Highest baud rate supported with the infrared modulator, in bit/s.
`define UMBS_IR_MAX_BAUD     115200

`endif

// ==== hw/umbs_sync.v ====
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ns
`default_nettype none

module umbs_sync #(
    parameter RESET_VALUE = 1'b1
) (
    input  wire sys_clk,
    input  wire reset_n,
    input  wire async_in,
    output reg  sync_out
);
    reg first_stage;

    // The first stage feeds only the second stage.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_stage <= RESET_VALUE;
            sync_out    <= RESET_VALUE;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end
endmodule // umbs_sync

`default_nettype wire

// ==== hw/umbs_rx_fifo.v ====
// Two-entry receive FIFO holding each character with its status bits.
`timescale 1ns/1ns
`default_nettype none

module umbs_rx_fifo #(
    parameter WIDTH = 10
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             flush,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    output wire [WIDTH-1:0] head_data,
    output wire             empty,
    output wire             full
);
    reg [WIDTH-1:0] store [0:1];
    reg             wr_idx;
    reg             rd_idx;
    reg [1:0]       count;

    assign empty     = (count == 2'h0);
    assign full      = (count == 2'h2);
    assign head_data = empty ? {WIDTH{1'b0}} : store[rd_idx];

    // Pointers and fill level; a push into a full FIFO is lost.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count  <= 2'h0;
        end else if (flush) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push && !full) begin
                wr_idx <= ~wr_idx;
            end
            if (pop && !empty) begin
                rd_idx <= ~rd_idx;
            end
            if ((push && !full) && !(pop && !empty)) begin
                count <= count + 2'h1;
            end else if (!(push && !full) && (pop && !empty)) begin
                count <= count - 2'h1;
            end
        end
    end

    // Storage takes data only on an accepted push.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            store[0] <= {WIDTH{1'b0}};
            store[1] <= {WIDTH{1'b0}};
        end else if (push && !full && !flush) begin
            store[wr_idx] <= push_data;
        end
    end
endmodule // umbs_rx_fifo

`default_nettype wire

// ==== verification/umbs_props.sv ====
// Checker of bus timing and port relations of the serial port block.
`timescale 1ns/1ns
`default_nettype none
module umbs_props (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        txd_pin,
    input wire logic        lut_one_out,
    input wire logic        usart_serial_out,
    input wire logic        infrared_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // A read is complete at the edge where waitrequest is low.
    wire logic rd_done;
    assign rd_done = avs_read && !avs_waitrequest;
    property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
    property p_wait_one; avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    property p_unmapped; rd_done && avs_address[3:2] == 2'h3 |-> avs_readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_data_up; rd_done && avs_address == 4'h0 |-> avs_readdata[31:8] == 24'h0; endproperty
    a_data_up: assert property (p_data_up) else $error("data upper bits");
    property p_st_zero; rd_done && avs_address == 4'h4 |-> avs_readdata[2:1] == 2'h0; endproperty
    a_st_zero: assert property (p_st_zero) else $error("status spare bits");
    // The pin is fed by the transmitter or by the encoder table.
    property p_tx_src;
        txd_pin == $past(lut_one_out) || txd_pin == $past(usart_serial_out);
    endproperty
    a_tx_src: assert property (p_tx_src) else $error("txd source");
    property p_ir_hold;
        !$stable(infrared_enable) |-> $past(avs_write && !avs_waitrequest && avs_address == 4'h8);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("infrared moved");
    property p_idle; !$past(reset_n) |-> txd_pin && usart_serial_out; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
endmodule // umbs_props
`default_nettype wire

// ==== verification/umbs_peer.sv ====
// Model of another port on the shared line that sends whole frames.
`timescale 1ns/1ns
`default_nettype none
module umbs_peer (
    input wire logic sys_clk,
    input wire logic tick,
    output var logic line
);
    initial line = 1'b1;
    // One bit lasts sixteen strobes; the line idles high between frames.
    task automatic bit_out(input logic b);
        integer k;
        line <= b;
        k = 0;
        while (k < 16) begin
            @(posedge sys_clk);
            if (tick) k = k + 1;
        end
    endtask
    // The marker is the ninth bit or the first stop; one high stop bit follows it.
    task automatic send(input logic [7:0] d, input integer n, input logic mk);
        integer i;
        bit_out(1'b0);
        for (i = 0; i < n && i < 8; i = i + 1) bit_out(d[i]);
        bit_out(mk);
        bit_out(1'b1);
    endtask
endmodule // umbs_peer
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the multidrop serial port block.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        sys_clk, reset_n, tick, use_lut, lut_one, avs_read, avs_write;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, rdata;
    logic [7:0]  d;
    wire logic [31:0] avs_readdata;
    wire logic   waitreq, txd, ser, ir, dma, line;
    integer      fails, total_checks, seed, i;
    umbs_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(waitreq),
        .baud_tick_x16(tick), .rxd_pin(use_lut ? 1'b1 : line), .txd_pin(txd),
        .lut_zero_out(use_lut ? line : 1'b1), .lut_one_out(lut_one),
        .usart_serial_out(ser), .infrared_enable(ir), .dma_request(dma));
    umbs_peer peer_u (.sys_clk(sys_clk), .tick(tick), .line(line));
    // Clock and a strobe every second cycle keep frames short.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) tick <= ~tick;
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Waitrequest and read data are taken at the rising edge that ends the request.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        integer n;
        logic w;
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        w = 1'b1;
        while (w && n < 50) begin
            @(posedge sys_clk);
            w = waitreq !== 1'b0;
            rdata = avs_readdata;
            n = n + 1;
        end
        if (w) begin
            fails = fails + 1;
            end_sim;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a); bus(1'b0, a, 32'h0); endtask
    task automatic ctrl(input logic [13:0] c); bus(1'b1, 4'h8, {18'h0, c}); endtask
    task automatic rx(input logic [7:0] v, input integer n, input logic mk);
        peer_u.send(v, n, mk);
        repeat (40) @(posedge sys_clk);
    endtask
    // A hang ends the run as a mismatch.
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails = fails + 1;
        end_sim;
    end
    initial begin
        {reset_n, tick, use_lut, lut_one, avs_read, avs_write} = 6'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        fails = 0;
        total_checks = 0;
        seed = 32'h40E1;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(4'h4); chk("status", 32'h20, rdata);
        rd(4'hC); chk("unmapped", 32'h0, rdata);
        // Nine-bit filtering: data dropped, address kept, then all data.
        d = $random(seed);
        ctrl(14'h2005);
        rx(d, 9, 1'b0); rd(4'h4); chk("dropped", 32'h20, rdata);
        rx(d, 9, 1'b1); rd(4'h4); chk("address", 32'hA1, rdata);
        rd(4'h0); chk("addr data", d, rdata);
        rd(4'h4); chk("empty", 32'h20, rdata);
        ctrl(14'h2001);
        rx(d, 9, 1'b0); rx(~d, 9, 1'b0);
        for (i = 0; i < 2; i++) begin
            rd(4'h4); chk("fifo st", 32'hA0, rdata);
            rd(4'h0); chk("fifo data", i ? {~d} : d, rdata);
        end
        $display("test filter done");
        // Eight-bit filtering with a stop marker, acknowledge and flush.
        ctrl(14'h1805);
        rx(d, 8, 1'b0); rd(4'h4); chk("stop drop", 32'h20, rdata);
        rx(d, 8, 1'b1); rd(4'h4); chk("stop keep", 32'hA0, rdata);
        bus(1'b1, 4'h4, 32'h80); rd(4'h4); chk("ack", 32'h20, rdata);
        rx(d, 8, 1'b1); rd(4'h4); chk("repush", 32'hA0, rdata);
        ctrl(14'h1800); ctrl(14'h1805);
        rd(4'h4); chk("flush", 32'h20, rdata);
        // Every short size returns zero above the character.
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            ctrl({i[2:0], 11'h001});
            rx(d, i + 5, 1'b1);
            rd(4'h0); chk("short", d & (8'hFF >> (3 - i)), rdata);
        end
        use_lut <= 1'b1;
        ctrl(14'h1A01);
        rx(d, 8, 1'b1); rd(4'h0); chk("decode", d, rdata);
        use_lut <= 1'b0;
        $display("test receive done");
        // Variable length: bit 0 and the request follow unread data.
        ctrl(14'h1881);
        rx(d, 8, 1'b1); chk("dma", 32'h1, dma);
        rd(4'h4); chk("var st", 32'hA1, rdata);
        rd(4'h0); chk("dma off", 32'h0, dma);
        rd(4'h4); chk("sticky", 32'hA0, rdata);
        bus(1'b1, 4'h4, 32'h80); rd(4'h4); chk("w1c", 32'h20, rdata);
        // Single pin: two writes go out, the third finds the buffer full.
        ctrl(14'h180B);
        bus(1'b1, 4'h0, {24'h0, d}); bus(1'b1, 4'h0, {24'h0, ~d});
        rd(4'h4); chk("buf full", 32'h0, rdata[5]);
        bus(1'b1, 4'h0, 32'h3C);
        repeat (900) @(posedge sys_clk);
        rd(4'h0); chk("loop a", d, rdata);
        rd(4'h0); chk("loop b", {~d}, rdata);
        // Both frames gone and read: only transmit-complete and buffer-empty stay.
        rd(4'h4); chk("loop end", 32'h60, rdata);
        // Encoder path drives the pin; infrared follows its control bit.
        ctrl(14'h0122);
        for (i = 0; i < 4; i++) begin
            lut_one <= i[0];
            repeat (3) @(posedge sys_clk);
            chk("encode", i[0], txd);
        end
        chk("infrared", 32'h1, ir);
        $display("test transmit done");
        end_sim;
    end
endmodule // tb
bind umbs_top umbs_props chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_pin(txd_pin),
    .lut_one_out(lut_one_out), .usart_serial_out(usart_serial_out),
    .infrared_enable(infrared_enable));
`default_nettype wire
